// file: core/pcs_serial_port.v
// pcm codec serial port: framing, slot timing, standby, signalling and straps
//
// Function
// - receive bit clock strapped to negative rail selects fixed-rate mode
// - otherwise variable-rate mode; that pin is the receive bit clock
// - fixed mode: double-length receive sync marks signalling frame, single-length normal
// - receive channel enters standby after receive sync low 300 ms
// - transmit channel enters standby after transmit sync low 300 ms, independently
// - transmit sync/slot enable follows receive conventions, independent of receive
// - receive word sampled on eight falling edges of the receive data clock
// - transmit word driven on eight rising edges of the transmit data clock
// - device inactive while power-down select low, active while high
// - fixed mode: signalling output holds eighth bit of last signalling frame
// - law strap at negative rail selects a-law, else mu-law
// - fixed mode, mu-law only: law input level sent as eighth bit in transmit signalling frames
// - fixed mode: slot strobe is open-drain output asserted during transmit slot
// - variable mode: slot strobe pin becomes transmit bit clock input
// - master frequency strap: negative 2.048, ground 1.544, positive 1.536 MHz
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.vh"
module pcs_serial_port
#(
    parameter STANDBY_CYCLES = `PCS_STANDBY_CYCLES
)
(
    input  wire       CLK_I,
    input  wire       RST_I,
    input  wire       RX_MASTER_CLOCK_I,
    input  wire       TX_MASTER_CLOCK_I,
    input  wire       RX_BIT_CLOCK_I,
    input  wire [1:0] RX_RATE_STRAP_I,
    input  wire       RX_FRAME_SYNC_SLOT_ENABLE_I,
    input  wire       TX_FRAME_SYNC_SLOT_ENABLE_I,
    input  wire       RX_PCM_DATA_I,
    input  wire [7:0] TX_CODE_WORD_I,
    input  wire       POWER_DOWN_SELECT_I,
    input  wire [1:0] LAW_SELECT_STRAP_I,
    input  wire       LAW_SELECT_TX_SIGNALLING_IN_I,
    input  wire [1:0] MASTER_FREQ_STRAP_I,
    input  wire       TX_SLOT_STROBE_OR_BIT_CLOCK_I,
    output reg        TX_SLOT_STROBE_OR_BIT_CLOCK_O,
    output reg        TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O,
    output reg        TX_PCM_DATA_O,
    output reg        TX_PCM_DATA_OE_O,
    output reg        RX_SIGNALLING_BIT_OUT_O,
    output reg  [7:0] RX_CODE_WORD_O,
    output reg        RX_WORD_VALID_O,
    output reg        RX_WORD_SIGNALLING_O,
    output reg        TX_WORD_TAKEN_O,
    output reg        FIXED_RATE_O,
    output reg        A_LAW_O,
    output reg  [1:0] MASTER_FREQ_O,
    output reg        RX_STANDBY_O,
    output reg        TX_STANDBY_O,
    output reg        ACTIVE_O
);
    // ==========================================================
    // pin synchronisers
    wire rx_mclk_s;
    wire tx_mclk_s;
    wire rx_dclk_s;
    wire tx_dclk_s;
    wire rx_fs_s;
    wire tx_fs_s;
    wire rx_data_s;
    wire pdn_s;
    wire sig_in_s;
    wire [8:0] pin_raw;
    wire [8:0] pin_sync;
    assign pin_raw = {RX_MASTER_CLOCK_I, TX_MASTER_CLOCK_I, RX_BIT_CLOCK_I, TX_SLOT_STROBE_OR_BIT_CLOCK_I,
                      RX_FRAME_SYNC_SLOT_ENABLE_I, TX_FRAME_SYNC_SLOT_ENABLE_I, RX_PCM_DATA_I,
                      POWER_DOWN_SELECT_I, LAW_SELECT_TX_SIGNALLING_IN_I};
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1)
        begin : g_sync
            pcs_sync u_sync
            (
                .CLK_I (CLK_I),
                .RST_I (RST_I),
                .d_i   (pin_raw[gi]),
                .q_o   (pin_sync[gi])
            );
        end
    endgenerate
    assign {rx_mclk_s, tx_mclk_s, rx_dclk_s, tx_dclk_s, rx_fs_s, tx_fs_s, rx_data_s, pdn_s, sig_in_s} = pin_sync;

    // ==========================================================
    // straps and mode; straps are static so they bypass the synchronisers and are decoded directly
    wire fixed_mode = (RX_RATE_STRAP_I == `PCS_STRAP_NEG);
    wire a_law      = (LAW_SELECT_STRAP_I == `PCS_STRAP_NEG);
    wire active     = pdn_s;

    // ==========================================================
    // data clock edges: master clocks in fixed mode, bit clocks in variable mode
    reg  rx_clk_prev_reg;
    reg  tx_clk_prev_reg;
    wire rx_clk = fixed_mode ? rx_mclk_s : rx_dclk_s;
    wire tx_clk = fixed_mode ? tx_mclk_s : tx_dclk_s;
    wire rx_fall = rx_clk_prev_reg & ~rx_clk;
    wire tx_rise = ~tx_clk_prev_reg & tx_clk;
    wire tx_fall = tx_clk_prev_reg & ~tx_clk;

    // ==========================================================
    // receive slot: sync pulse length counted in data clocks
    reg [3:0] rx_cnt_reg;
    reg [2:0] rx_fs_len_reg;
    reg       rx_busy_reg;
    reg [7:0] rx_sh_reg;
    always @(posedge CLK_I)
    begin
        if (RST_I || !active)
        begin
            // tracks the pin while idle so waking from power-down sees no false edge
            rx_clk_prev_reg  <= rx_clk;
            rx_cnt_reg       <= 4'h0;
            rx_fs_len_reg    <= 3'h0;
            rx_busy_reg      <= 1'b0;
            rx_sh_reg        <= 8'h00;
            RX_CODE_WORD_O   <= 8'h00;
            RX_WORD_VALID_O  <= 1'b0;
            RX_WORD_SIGNALLING_O <= 1'b0;
            RX_SIGNALLING_BIT_OUT_O <= 1'b0;
        end
        else
        begin
            rx_clk_prev_reg <= rx_clk;
            RX_WORD_VALID_O <= 1'b0;
            if (rx_fall)
            begin
                if (!rx_busy_reg && rx_fs_s)
                begin
                    rx_busy_reg   <= 1'b1;
                    rx_cnt_reg    <= 4'h1;
                    rx_fs_len_reg <= 3'h1;
                    rx_sh_reg     <= {rx_sh_reg[6:0], rx_data_s};
                end
                else if (rx_busy_reg && !fixed_mode && !rx_fs_s)
                    rx_busy_reg <= 1'b0;  // slot enable dropped early: word abandoned
                else if (rx_busy_reg)
                begin
                    rx_sh_reg  <= {rx_sh_reg[6:0], rx_data_s};
                    rx_cnt_reg <= rx_cnt_reg + 4'h1;
                    if (rx_fs_s && rx_fs_len_reg == rx_cnt_reg[2:0])
                        rx_fs_len_reg <= rx_fs_len_reg + 3'h1;
                    if (rx_cnt_reg == `PCS_WORD_BITS - 1)
                    begin
                        rx_busy_reg      <= 1'b0;
                        RX_CODE_WORD_O   <= {rx_sh_reg[6:0], rx_data_s};
                        RX_WORD_VALID_O  <= 1'b1;
                        // sync held two clocks or more marks a signalling frame
                        RX_WORD_SIGNALLING_O <= fixed_mode && (rx_fs_len_reg >= 3'h2);
                        if (fixed_mode && rx_fs_len_reg >= 3'h2)
                            RX_SIGNALLING_BIT_OUT_O <= rx_data_s;
                    end
                end
            end
        end
    end

    // ==========================================================
    // transmit slot, mirror of receive
    reg [3:0] tx_cnt_reg;
    reg [2:0] tx_fs_len_reg;
    reg       tx_busy_reg;
    reg [7:0] tx_sh_reg;
    always @(posedge CLK_I)
    begin
        if (RST_I || !active)
        begin
            tx_clk_prev_reg <= tx_clk;
            tx_cnt_reg      <= 4'h0;
            tx_fs_len_reg   <= 3'h0;
            tx_busy_reg     <= 1'b0;
            tx_sh_reg       <= 8'h00;
            TX_PCM_DATA_O   <= 1'b0;
            TX_PCM_DATA_OE_O <= 1'b0;
            TX_WORD_TAKEN_O <= 1'b0;
            TX_SLOT_STROBE_OR_BIT_CLOCK_O  <= 1'b0;
            TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O <= 1'b0;
        end
        else
        begin
            tx_clk_prev_reg <= tx_clk;
            TX_WORD_TAKEN_O <= 1'b0;
            if (tx_rise)
            begin
                if (!tx_busy_reg && tx_fs_s)
                begin
                    tx_busy_reg      <= 1'b1;
                    tx_cnt_reg       <= 4'h1;
                    tx_fs_len_reg    <= 3'h1;
                    tx_sh_reg        <= {TX_CODE_WORD_I[6:0], 1'b0};
                    TX_WORD_TAKEN_O  <= 1'b1;
                    TX_PCM_DATA_O    <= TX_CODE_WORD_I[7];
                    TX_PCM_DATA_OE_O <= 1'b1;
                    TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O <= fixed_mode;
                end
                else if (tx_busy_reg && !fixed_mode && !tx_fs_s)
                begin
                    tx_busy_reg      <= 1'b0;
                    TX_PCM_DATA_OE_O <= 1'b0;
                end
                else if (tx_busy_reg && tx_cnt_reg == `PCS_WORD_BITS)
                begin
                    tx_busy_reg      <= 1'b0;
                    TX_PCM_DATA_OE_O <= 1'b0;
                    TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O <= 1'b0;
                end
                else if (tx_busy_reg)
                begin
                    tx_cnt_reg <= tx_cnt_reg + 4'h1;
                    tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0};
                    if (tx_fs_s && tx_fs_len_reg == tx_cnt_reg[2:0])
                        tx_fs_len_reg <= tx_fs_len_reg + 3'h1;
                    // in mu-law only, last bit of a signalling frame carries the law pin level
                    if (tx_cnt_reg == `PCS_WORD_BITS - 1 && fixed_mode && !a_law
                        && (tx_fs_len_reg >= 3'h2 || (tx_fs_s && tx_fs_len_reg == 3'h1)))
                        TX_PCM_DATA_O <= sig_in_s;
                    else
                        TX_PCM_DATA_O <= tx_sh_reg[7];
                end
            end
            else if (tx_fall && tx_busy_reg && tx_cnt_reg == `PCS_WORD_BITS && fixed_mode)
            begin
                // strobe released on the falling edge inside the eighth bit so it brackets the slot
                tx_busy_reg      <= 1'b0;
                TX_PCM_DATA_OE_O <= 1'b0;
                TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O <= 1'b0;
            end
        end
    end

    // ==========================================================
    // standby timers: each channel counts its own sync low time
    reg [31:0] rx_idle_reg;
    reg [31:0] tx_idle_reg;
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            rx_idle_reg    <= 32'h0;
            tx_idle_reg    <= 32'h0;
            RX_STANDBY_O   <= 1'b0;
            TX_STANDBY_O   <= 1'b0;
            FIXED_RATE_O   <= 1'b0;
            A_LAW_O        <= 1'b0;
            MASTER_FREQ_O  <= `PCS_FREQ_2048;
            ACTIVE_O       <= 1'b0;
        end
        else
        begin
            FIXED_RATE_O  <= fixed_mode;
            A_LAW_O       <= a_law ? `PCS_LAW_A : `PCS_LAW_MU;
            ACTIVE_O      <= active;
            case (MASTER_FREQ_STRAP_I)
                `PCS_STRAP_NEG: MASTER_FREQ_O <= `PCS_FREQ_2048;
                `PCS_STRAP_GND: MASTER_FREQ_O <= `PCS_FREQ_1544;
                `PCS_STRAP_POS: MASTER_FREQ_O <= `PCS_FREQ_1536;
                default:        MASTER_FREQ_O <= `PCS_FREQ_1544;
            endcase
            if (rx_fs_s)
                rx_idle_reg <= 32'h0;
            else if (rx_idle_reg < STANDBY_CYCLES)
                rx_idle_reg <= rx_idle_reg + 32'h1;
            if (tx_fs_s)
                tx_idle_reg <= 32'h0;
            else if (tx_idle_reg < STANDBY_CYCLES)
                tx_idle_reg <= tx_idle_reg + 32'h1;
            RX_STANDBY_O <= !rx_fs_s && (rx_idle_reg >= STANDBY_CYCLES - 1);
            TX_STANDBY_O <= !tx_fs_s && (tx_idle_reg >= STANDBY_CYCLES - 1);
        end
    end
endmodule
`default_nettype wire

// file: include/pcs_defines.vh
// shared constants for the pcm serial port block
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH
`define PCS_CLK_PERIOD_NS     10
`define PCS_STANDBY_TIME_MS   300
`define PCS_STANDBY_CYCLES    ((`PCS_STANDBY_TIME_MS * 1000000) / `PCS_CLK_PERIOD_NS)
`define PCS_WORD_BITS         8
`define PCS_STRAP_NEG         2'b00
`define PCS_STRAP_GND         2'b01
`define PCS_STRAP_POS         2'b10
`define PCS_FREQ_2048         2'b00
`define PCS_FREQ_1544         2'b01
`define PCS_FREQ_1536         2'b10
`define PCS_LAW_MU            1'b0
`define PCS_LAW_A             1'b1
`endif

// file: core/pcs_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pcs_sync
(
    input  wire CLK_I,
    input  wire RST_I,
    input  wire d_i,
    output reg  q_o
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    // the first stage feeds only the second; q changes once stages two and three agree
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_o    <= 1'b0;
        end
        else
        begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                q_o <= s3_reg;
        end
    end
endmodule
`default_nettype wire

// file: tb/pcs_serial_port_properties.sv
// concurrent checks on the pcm serial port pins
`timescale 1ns/1ps
`default_nettype none
module pcs_serial_port_properties
#(
    parameter STANDBY_CYCLES = 50
)
(
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic [1:0] RX_RATE_STRAP_I,
    input  wire logic [1:0] LAW_SELECT_STRAP_I,
    input  wire logic       POWER_DOWN_SELECT_I,
    input  wire logic       RX_FRAME_SYNC_SLOT_ENABLE_I,
    input  wire logic       TX_FRAME_SYNC_SLOT_ENABLE_I,
    input  wire logic       TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O,
    input  wire logic       TX_PCM_DATA_OE_O,
    input  wire logic       RX_WORD_VALID_O,
    input  wire logic       FIXED_RATE_O,
    input  wire logic       A_LAW_O,
    input  wire logic       RX_STANDBY_O,
    input  wire logic       TX_STANDBY_O
);
    // ==========================================
    // helper counters: slot length and sync-low time
    int oe_n;
    int rx_lo;
    int tx_lo;
    always @(posedge CLK_I)
    begin
        oe_n  <= (RST_I || !TX_PCM_DATA_OE_O) ? 0 : oe_n + 1;
        rx_lo <= (RST_I || RX_FRAME_SYNC_SLOT_ENABLE_I) ? 0 : rx_lo + 1;
        tx_lo <= (RST_I || TX_FRAME_SYNC_SLOT_ENABLE_I) ? 0 : tx_lo + 1;
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ==========================================
    // assertions; standby edges get a margin for the pin synchronisers
    a_rate_strap: assert property
        ($stable(RX_RATE_STRAP_I) [*6] |-> FIXED_RATE_O == (RX_RATE_STRAP_I == 2'b00))
        else $error("rate mode does not follow strap");
    a_law_strap: assert property
        ($stable(LAW_SELECT_STRAP_I) [*6] |-> A_LAW_O == (LAW_SELECT_STRAP_I == 2'b00))
        else $error("law select does not follow strap");
    a_strobe_fixed_only: assert property
        (TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O |-> FIXED_RATE_O)
        else $error("slot strobe driven in variable mode");
    a_valid_single: assert property
        (RX_WORD_VALID_O |=> !RX_WORD_VALID_O)
        else $error("receive valid longer than one cycle");
    a_slot_length: assert property
        ($fell(TX_PCM_DATA_OE_O) && FIXED_RATE_O |-> oe_n inside {[60:76]})
        else $error("transmit slot length wrong");
    a_inactive_quiet: assert property
        (!POWER_DOWN_SELECT_I [*6] |-> !TX_PCM_DATA_OE_O && !RX_WORD_VALID_O && !TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O)
        else $error("activity while powered down");
    a_rx_standby: assert property
        (rx_lo > 10 && (rx_lo < STANDBY_CYCLES - 8 || rx_lo > STANDBY_CYCLES + 8)
         |-> RX_STANDBY_O == (rx_lo > STANDBY_CYCLES))
        else $error("receive standby timing wrong");
    a_tx_standby: assert property
        (tx_lo > 10 && (tx_lo < STANDBY_CYCLES - 8 || tx_lo > STANDBY_CYCLES + 8)
         |-> TX_STANDBY_O == (tx_lo > STANDBY_CYCLES))
        else $error("transmit standby timing wrong");
    c_rx_word: cover property (RX_WORD_VALID_O);
    c_tx_slot: cover property ($fell(TX_PCM_DATA_OE_O));
    c_standby: cover property ($rose(RX_STANDBY_O));
endmodule
`default_nettype wire

// file: tb/pcs_highway_model.sv
// far-end highway model: master clock, frame sync, receive data, transmit capture
`timescale 1ns/1ps
`default_nettype none
module pcs_highway_model
(
    input  wire logic       start_i,
    input  wire logic [7:0] word_i,
    input  wire logic       sig_i,
    input  wire logic       var_i,
    input  wire logic       tx_d_i,
    input  wire logic       tx_oe_i,
    output logic            mclk_o,
    output logic            fs_o,
    output logic            rx_d_o,
    output logic [7:0]      cap_o,
    output logic [3:0]      ncap_o,
    output logic            done_o
);
    integer i;
    initial
    begin
        mclk_o = 1'b0;
        fs_o = 1'b0;
        rx_d_o = 1'b0;
        done_o = 1'b1;
    end
    always #40 mclk_o = ~mclk_o;
    // ==========================================
    // one frame; data moves a quarter period before the rising edge
    always @(posedge start_i)
    begin
        done_o = 1'b0;
        ncap_o = 4'h0;
        @(negedge mclk_o);
        #20;
        fs_o = 1'b1;
        for (i = 0; i < 9; i = i + 1)
        begin
            if (i == 1 && !sig_i && !var_i) fs_o = 1'b0;
            if (i == 2 && !var_i) fs_o = 1'b0;
            rx_d_o = (i < 8) ? word_i[7 - i] : ~rx_d_o;
            @(posedge mclk_o);
            if (tx_oe_i)
            begin
                cap_o = {cap_o[6:0], tx_d_i};
                ncap_o = ncap_o + 4'h1;
            end
            #60;
        end
        fs_o = 1'b0;
        done_o = 1'b1;
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the pcm serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int SC = 200;
    logic       clk = 1'b0, rst = 1'b1, power_down_select = 1'b1, start = 1'b0, sig = 1'b0, vr = 1'b0, lin = 1'b0, txh = 1'b0;
    logic [1:0] rate = 2'b00, law = 2'b01, frq = 2'b00, mf;
    logic [7:0] rxw = 8'h00, txw = 8'h00, cap, rxo;
    logic [3:0] ncap;
    logic       mclk, fs, rxd, done, txd, txoe, sto, sd, vld, wsig, rx_signalling_bit_out, fix, alaw, rsb, tsb, act, tkn;
    logic       seen = 1'b0;
    int         n_mismatch = 0, num_checks = 0, nval = 0, ntk = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (vld) nval <= nval + 1;
    always @(posedge clk) if (tkn) ntk <= ntk + 1;
    // the open-drain strobe only counts when it really pulls the pin low
    always @(posedge clk) if (sto && sd === 1'b0) seen <= 1'b1;
    pcs_serial_port #(.STANDBY_CYCLES(SC)) u_dut
    (
        .CLK_I(clk), .RST_I(rst), .RX_MASTER_CLOCK_I(mclk), .TX_MASTER_CLOCK_I(mclk),
        .RX_BIT_CLOCK_I(vr & mclk), .RX_RATE_STRAP_I(rate), .RX_FRAME_SYNC_SLOT_ENABLE_I(fs),
        .TX_FRAME_SYNC_SLOT_ENABLE_I(fs | txh), .RX_PCM_DATA_I(rxd), .TX_CODE_WORD_I(txw),
        .POWER_DOWN_SELECT_I(power_down_select), .LAW_SELECT_STRAP_I(law), .LAW_SELECT_TX_SIGNALLING_IN_I(lin),
        .MASTER_FREQ_STRAP_I(frq), .TX_SLOT_STROBE_OR_BIT_CLOCK_I(sto ? sd : (vr ? mclk : 1'b1)),
        .TX_SLOT_STROBE_OR_BIT_CLOCK_O(sd), .TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O(sto), .TX_PCM_DATA_O(txd),
        .TX_PCM_DATA_OE_O(txoe), .RX_SIGNALLING_BIT_OUT_O(rx_signalling_bit_out), .RX_CODE_WORD_O(rxo), .RX_WORD_VALID_O(vld),
        .RX_WORD_SIGNALLING_O(wsig), .TX_WORD_TAKEN_O(tkn), .FIXED_RATE_O(fix), .A_LAW_O(alaw),
        .MASTER_FREQ_O(mf), .RX_STANDBY_O(rsb), .TX_STANDBY_O(tsb), .ACTIVE_O(act)
    );
    pcs_highway_model u_far
    (
        .start_i(start), .word_i(rxw), .sig_i(sig), .var_i(vr), .tx_d_i(txd), .tx_oe_i(txoe),
        .mclk_o(mclk), .fs_o(fs), .rx_d_o(rxd), .cap_o(cap), .ncap_o(ncap), .done_o(done)
    );
    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // the far end owns frame timing; the slot itself runs at master clock pace
    task automatic frame(input logic [7:0] r, input logic [7:0] t, input logic s, input int nv);
        int v;
        int k;
        v = nval;
        k = ntk;
        rxw = r;
        txw = t;
        sig = s;
        seen = 1'b0;
        start = 1'b1;
        wt(1);
        while (!done) wt(1);
        start = 1'b0;
        wt(20);
        chk("valid count", 8'(nv), 8'(nval - v));
        chk("tx oe after slot", 8'h00, {7'h0, txoe});
        chk("taken count", 8'(nv), 8'(ntk - k));
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_straps;
        for (int j = 0; j < 4; j++)
        begin
            frq = j[1:0];
            law = j[1:0];
            wt(10);
            // the unused strap code falls back to the middle frequency
            chk("master freq", (j == 3) ? 8'h01 : j[7:0], {6'h0, mf});
            chk("a law", {7'h0, j == 0}, {7'h0, alaw});
        end
        law = 2'b01;
        $display("strap test done");
    endtask
    task automatic t_fixed;
        frame(8'ha5, 8'h3c, 1'b0, 1);
        chk("rx word", 8'ha5, rxo);
        chk("tx word", 8'h3c, cap);
        chk("tx bits", 8'h08, {4'h0, ncap});
        chk("sig flag", 8'h00, {7'h0, wsig});
        chk("strobe seen", 8'h01, {7'h0, seen});
        chk("fixed mode", 8'h01, {7'h0, fix});
        $display("fixed frame test done");
    endtask
    task automatic t_signal;
        lin = 1'b1;
        frame(8'h81, 8'h3c, 1'b1, 1);
        chk("sig flag", 8'h01, {7'h0, wsig});
        chk("sig out", 8'h01, {7'h0, rx_signalling_bit_out});
        chk("tx sig word", 8'h3d, cap);
        frame(8'h80, 8'h3c, 1'b0, 1);
        chk("sig held", 8'h01, {7'h0, rx_signalling_bit_out});
        chk("tx plain word", 8'h3c, cap);
        law = 2'b00;
        frame(8'h80, 8'h3c, 1'b1, 1);
        chk("sig out", 8'h00, {7'h0, rx_signalling_bit_out});
        chk("tx a law word", 8'h3c, cap);
        law = 2'b01;
        lin = 1'b0;
        $display("signalling test done");
    endtask
    task automatic t_var;
        rate = 2'b10;
        vr = 1'b1;
        wt(10);
        chk("fixed mode", 8'h00, {7'h0, fix});
        rate = 2'b01;
        wt(10);
        chk("fixed mode", 8'h00, {7'h0, fix});
        frame(8'h5a, 8'hc3, 1'b0, 1);
        chk("rx word", 8'h5a, rxo);
        chk("tx word", 8'hc3, cap);
        chk("strobe seen", 8'h00, {7'h0, seen});
        rate = 2'b00;
        vr = 1'b0;
        wt(10);
        $display("variable rate test done");
    endtask
    task automatic t_pdn;
        power_down_select = 1'b0;
        wt(10);
        chk("active", 8'h00, {7'h0, act});
        frame(8'h11, 8'h22, 1'b0, 0);
        chk("tx bits", 8'h00, {4'h0, ncap});
        power_down_select = 1'b1;
        wt(10);
        chk("active", 8'h01, {7'h0, act});
        $display("power down test done");
    endtask
    task automatic t_standby;
        frame(8'h00, 8'h00, 1'b0, 1);
        // the frame itself already leaves sync low for about 85 cycles
        wt(SC - 140);
        chk("rx standby", 8'h00, {7'h0, rsb});
        wt(100);
        chk("rx standby", 8'h01, {7'h0, rsb});
        chk("tx standby", 8'h01, {7'h0, tsb});
        txh = 1'b1;
        wt(10);
        chk("tx standby", 8'h00, {7'h0, tsb});
        chk("rx standby", 8'h01, {7'h0, rsb});
        txh = 1'b0;
        $display("standby test done");
    endtask
    initial
    begin
        wt(20);
        rst = 1'b0;
        wt(5);
        t_straps;
        t_fixed;
        t_signal;
        t_var;
        t_pdn;
        t_standby;
        end_of_test;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        end_of_test;
    end
endmodule
bind pcs_serial_port pcs_serial_port_properties #(.STANDBY_CYCLES(STANDBY_CYCLES)) u_props
(
    .CLK_I(CLK_I), .RST_I(RST_I), .RX_RATE_STRAP_I(RX_RATE_STRAP_I), .LAW_SELECT_STRAP_I(LAW_SELECT_STRAP_I),
    .POWER_DOWN_SELECT_I(POWER_DOWN_SELECT_I), .RX_FRAME_SYNC_SLOT_ENABLE_I(RX_FRAME_SYNC_SLOT_ENABLE_I),
    .TX_FRAME_SYNC_SLOT_ENABLE_I(TX_FRAME_SYNC_SLOT_ENABLE_I), .TX_PCM_DATA_OE_O(TX_PCM_DATA_OE_O),
    .TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O(TX_SLOT_STROBE_OR_BIT_CLOCK_OE_O), .RX_WORD_VALID_O(RX_WORD_VALID_O),
    .FIXED_RATE_O(FIXED_RATE_O), .A_LAW_O(A_LAW_O), .RX_STANDBY_O(RX_STANDBY_O), .TX_STANDBY_O(TX_STANDBY_O)
);
`default_nettype wire
